// File: common/fp_led_pkg.sv
// constants and types for the front-panel status and identify indicator block
// assumes a single 250 MHz standby clock feeding every user of this package
package fp_led_pkg;

    // ********************************************************
    // timing
    // ********************************************************
    localparam int unsigned CLK_FREQ_HZ    = 250_000_000;
    localparam int unsigned BLINK_FREQ_HZ  = 1;
    // half a blink period in core clock cycles (50 percent duty)
    localparam int unsigned BLINK_HALF_CYC = CLK_FREQ_HZ / (2 * BLINK_FREQ_HZ);
    localparam int unsigned BLINK_CNT_W    = 28;

    // correctable memory errors tolerated before the non-fatal alarm
    localparam logic [7:0]  MEM_CE_LIMIT   = 8'h0A;

    // ********************************************************
    // register map (word offsets of the plain register port)
    // ********************************************************
    localparam logic [3:0] REG_FW_FAULT  = 4'h0;  // firmware fault report, rw
    localparam logic [3:0] REG_IDENT_CMD = 4'h1;  // identify command, write only
    localparam logic [3:0] REG_STATUS    = 4'h2;  // led and identify state, ro
    localparam logic [3:0] REG_MEM_CE    = 4'h3;  // memory error count and mode, rw

    // firmware fault report fields
    localparam int unsigned FW_DEGRADED  = 0;
    localparam int unsigned FW_NONFATAL  = 1;
    localparam int unsigned FW_FATAL     = 2;
    localparam int unsigned FW_W         = 3;

    // identify command fields
    localparam int unsigned ID_CMD_STD_ON    = 0;  // standard identify, set
    localparam int unsigned ID_CMD_VENDOR_ON = 1;  // vendor identify light, set
    localparam int unsigned ID_CMD_OFF       = 2;  // either command with off

    // memory error register fields
    localparam int unsigned MEM_CNT_LSB  = 0;
    localparam int unsigned MEM_MIRROR   = 8;
    localparam int unsigned MEM_CLR      = 9;

    // status register fields
    localparam int unsigned ST_SEV_LSB   = 0;
    localparam int unsigned ST_ID_LSB    = 4;

    localparam logic [31:0] RD_DEFAULT   = 32'h0000_0000;

    // ********************************************************
    // types
    // ********************************************************
    typedef enum logic [3:0]
    {
        SEV_OFF      = 4'h1,
        SEV_OK       = 4'h2,
        SEV_DEGRADED = 4'h4,
        SEV_NONFATAL = 4'h8
    } sev_low_t;

    // severity level ordering used by the priority encoder
    typedef enum logic [2:0]
    {
        LVL_OFF      = 3'h0,
        LVL_OK       = 3'h1,
        LVL_DEGRADED = 3'h2,
        LVL_NONFATAL = 3'h3,
        LVL_FATAL    = 3'h4
    } sev_lvl_t;

    typedef enum logic [2:0]
    {
        ID_OFF    = 3'h1,
        ID_SOLID  = 3'h2,
        ID_BLINK  = 3'h4
    } id_state_t;

endpackage

// File: hdl/fp_blink_div.sv
// shared blink divider: free-running half-period counter toggling a phase bit
// assumes core_clk at the package rate and an asynchronous active-low reset
`timescale 1ns/1ps
`default_nettype none

module fp_blink_div
(
    input  wire logic core_clk,
    input  wire logic arst_n,
    output var  logic blink_phase,
    output var  logic tick
);

    logic [fp_led_pkg::BLINK_CNT_W-1:0] cnt;
    logic [fp_led_pkg::BLINK_CNT_W-1:0] next_cnt;
    logic                               next_phase;
    logic                               wrap;

    // count one half period, then flip the phase and pulse tick
    always_comb
    begin
        wrap       = (cnt == fp_led_pkg::BLINK_CNT_W'(fp_led_pkg::BLINK_HALF_CYC - 1));
        next_cnt   = wrap ? '0 : cnt + 1'b1;
        next_phase = wrap ? ~blink_phase : blink_phase;
    end

    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            cnt         <= '0;
            blink_phase <= 1'b0;
            tick        <= 1'b0;
        end
        else
        begin
            cnt         <= next_cnt;
            blink_phase <= next_phase;
            tick        <= wrap;
        end
    end

endmodule

`default_nettype wire

// File: hdl/fp_status_id_led.sv
// front-panel system status (bicolour) and chassis identify indicator logic
// assumes standby power and clock; fault inputs and the button are asynchronous
// pins, register port runs on core_clk
//
// The implementer's own choices: the strobed register port and the register addresses.
`timescale 1ns/1ps
`default_nettype none

module fp_status_id_led
(
    input  wire logic        core_clk,
    input  wire logic        arst_n,
    // degraded sensor conditions (asynchronous)
    input  wire logic        supply_redundancy_lost,
    input  wire logic        fan_redundancy_lost,
    input  wire logic        supply_redundant,
    input  wire logic        fan_redundant,
    input  wire logic        one_cpu_disabled,
    input  wire logic        fan_failed,
    input  wire logic        noncritical_crossed,
    input  wire logic        battery_failed,
    input  wire logic        supply_predictive_fail,
    input  wire logic        link_correctable_err,
    // non-fatal sensor conditions
    input  wire logic        critical_crossed,
    input  wire logic        regulator_overtemp,
    input  wire logic        fans_insufficient,
    input  wire logic        link_uncorrectable_err,
    // fatal sensor conditions
    input  wire logic        cpu_catastrophic_error,
    input  wire logic        cpu_thermal_trip,
    input  wire logic        cpu1_missing,
    input  wire logic        power_good,
    input  wire logic        supplies_insufficient,
    input  wire logic        cpu_config_mismatch,
    // other controllers, already on core_clk, and the asynchronous identify button pin, which goes through the synchronisers
    input  wire logic [2:0]  ctrl_fault,
    input  wire logic        system_ready,
    input  wire logic        ident_button_n,
    // register port
    input  wire logic [3:0]  reg_addr,
    input  wire logic [31:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output var  logic [31:0] reg_rdata,
    // lamps, active high drive
    output var  logic        status_green,
    output var  logic        status_amber,
    output var  logic        ident_light
);

    localparam int unsigned NSENS = 19;

    // ********************************************************
    // pin synchronisers
    // ********************************************************
    logic [NSENS-1:0] raw_in;
    logic [NSENS-1:0] sync1;
    logic [NSENS-1:0] sync2;
    logic [NSENS-1:0] sync3;
    logic [NSENS-1:0] sens;
    logic [NSENS-1:0] next_sens;

    assign raw_in = {~ident_button_n, supply_redundancy_lost, fan_redundancy_lost, supply_redundant,
                     fan_redundant, one_cpu_disabled, fan_failed, noncritical_crossed, battery_failed,
                     supply_predictive_fail, link_correctable_err, critical_crossed, regulator_overtemp,
                     fans_insufficient, link_uncorrectable_err, cpu_catastrophic_error,
                     cpu_thermal_trip, cpu1_missing, ~power_good};
    // a change counts only once the second and third stage agree
    always_comb
    begin
        for (int i = 0; i < NSENS; i++)
        begin
            next_sens[i] = (sync2[i] == sync3[i]) ? sync3[i] : sens[i];
        end
    end

    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            sync1 <= '0;
            sync2 <= '0;
            sync3 <= '0;
            sens  <= '0;
        end
        else
        begin
            sync1 <= raw_in;
            sync2 <= sync1;
            sync3 <= sync2;
            sens  <= next_sens;
        end
    end

    // ********************************************************
    // register state
    // ********************************************************
    logic [fp_led_pkg::FW_W-1:0] fw_fault;
    logic [fp_led_pkg::FW_W-1:0] next_fw_fault;
    logic [7:0]                  mem_ce;
    logic [7:0]                  next_mem_ce;
    logic [8:0]                  mem_sum;
    logic                        mem_mirror;
    logic                        next_mem_mirror;
    logic [31:0]                 next_rdata;
    logic                        button_press;
    logic                        button_q;
    logic                        cmd_on;
    logic                        cmd_off;
    fp_led_pkg::sev_lvl_t        sev;
    fp_led_pkg::id_state_t       id_state;

    assign cmd_on  = reg_wr && (reg_addr == fp_led_pkg::REG_IDENT_CMD)
                     && (reg_wdata[fp_led_pkg::ID_CMD_STD_ON] || reg_wdata[fp_led_pkg::ID_CMD_VENDOR_ON]);
    assign cmd_off = reg_wr && (reg_addr == fp_led_pkg::REG_IDENT_CMD) && reg_wdata[fp_led_pkg::ID_CMD_OFF];

    // firmware writes, memory error counting and read mux
    always_comb
    begin
        next_fw_fault   = fw_fault;
        next_mem_ce     = mem_ce;
        next_mem_mirror = mem_mirror;
        next_rdata      = fp_led_pkg::RD_DEFAULT;
        mem_sum         = {1'b0, mem_ce} + {1'b0, reg_wdata[7:0]};
        if (reg_wr && reg_addr == fp_led_pkg::REG_FW_FAULT)
        begin
            next_fw_fault = reg_wdata[fp_led_pkg::FW_W-1:0];
        end
        if (reg_wr && reg_addr == fp_led_pkg::REG_MEM_CE)
        begin
            next_mem_mirror = reg_wdata[fp_led_pkg::MEM_MIRROR];
            // clear restarts the monitoring window, else the written count is added
            if (reg_wdata[fp_led_pkg::MEM_CLR])
            begin
                next_mem_ce = '0;
            end
            else
            begin
                next_mem_ce = mem_sum[8] ? 8'hFF : mem_sum[7:0]; // saturate rather than wrap back below the limit
            end
        end
        if (reg_rd)
        begin
            unique case (reg_addr)
                fp_led_pkg::REG_FW_FAULT:
                    next_rdata = {29'h0000_0000, fw_fault};
                fp_led_pkg::REG_STATUS:
                    next_rdata = {25'h000_0000, id_state, 1'b0, sev};
                fp_led_pkg::REG_MEM_CE:
                    next_rdata = {23'h00_0000, mem_mirror, mem_ce};
                default:
                    next_rdata = fp_led_pkg::RD_DEFAULT; // unmapped and write-only read zero
            endcase
        end
    end

    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            fw_fault   <= '0;
            mem_ce     <= '0;
            mem_mirror <= 1'b0;
            reg_rdata  <= '0;
            button_q   <= 1'b0;
        end
        else
        begin
            fw_fault   <= next_fw_fault;
            mem_ce     <= next_mem_ce;
            mem_mirror <= next_mem_mirror;
            reg_rdata  <= next_rdata;
            button_q   <= sens[NSENS-1];
        end
    end

    assign button_press = sens[NSENS-1] && !button_q;

    // ********************************************************
    // severity evaluation
    // ********************************************************
    logic                 deg_any;
    logic                 nonfatal_any;
    logic                 fatal_any;
    logic [3:0]           fill;
    fp_led_pkg::sev_lvl_t next_sev;

    // sensor terms are combinational on the live synchronised state (supplies_insufficient and cpu_config_mismatch unsynchronised), so they clear on deassert
    always_comb
    begin
        deg_any = (sens[17] && sens[15])
                  || (sens[16] && sens[14])
                  || (|sens[13:8])
                  || fw_fault[fp_led_pkg::FW_DEGRADED]
                  || ctrl_fault[fp_led_pkg::FW_DEGRADED];
        nonfatal_any = (|sens[7:4])
                       || (!mem_mirror && mem_ce > fp_led_pkg::MEM_CE_LIMIT)
                       || fw_fault[fp_led_pkg::FW_NONFATAL]
                       || ctrl_fault[fp_led_pkg::FW_NONFATAL];
        fatal_any = (|sens[3:0]) || supplies_insufficient || cpu_config_mismatch
                    || fw_fault[fp_led_pkg::FW_FATAL]
                    || ctrl_fault[fp_led_pkg::FW_FATAL];
        // highest active severity wins, amber above green
        if (fatal_any)
        begin
            next_sev = fp_led_pkg::LVL_FATAL;
        end
        else if (nonfatal_any)
        begin
            next_sev = fp_led_pkg::LVL_NONFATAL;
        end
        else if (deg_any)
        begin
            next_sev = fp_led_pkg::LVL_DEGRADED;
        end
        else if (system_ready)
        begin
            next_sev = fp_led_pkg::LVL_OK;
        end
        else
        begin
            next_sev = fp_led_pkg::LVL_OFF;
        end
    end

    // status stays dark until three sync stages and the filter hold real pin values
    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            sev  <= fp_led_pkg::LVL_OFF;
            fill <= '0;
        end
        else
        begin
            fill <= {fill[2:0], 1'b1};
            sev  <= fill[3] ? next_sev : fp_led_pkg::LVL_OFF; // held on standby power
        end
    end

    // ********************************************************
    // identify state machine
    // ********************************************************
    fp_led_pkg::id_state_t next_id_state;

    // latest event decides; a command in the same cycle as a press is the newer
    always_comb
    begin
        next_id_state = id_state;
        unique case (id_state)
            fp_led_pkg::ID_OFF:
                next_id_state = button_press ? fp_led_pkg::ID_SOLID : fp_led_pkg::ID_OFF;
            fp_led_pkg::ID_SOLID:
                next_id_state = button_press ? fp_led_pkg::ID_OFF : fp_led_pkg::ID_SOLID;
            fp_led_pkg::ID_BLINK:
                next_id_state = button_press ? fp_led_pkg::ID_SOLID : fp_led_pkg::ID_BLINK;
            default:
                next_id_state = fp_led_pkg::ID_OFF;
        endcase
        if (cmd_on)
        begin
            next_id_state = fp_led_pkg::ID_BLINK;
        end
        else if (cmd_off)
        begin
            next_id_state = fp_led_pkg::ID_OFF;
        end
    end

    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            id_state <= fp_led_pkg::ID_OFF;
        end
        else
        begin
            id_state <= next_id_state;
        end
    end

    // ********************************************************
    // lamp drive
    // ********************************************************
    logic blink_phase;
    logic next_green;
    logic next_amber;
    logic next_ident;

    // one divider for both lamps keeps them in phase
    fp_blink_div u_blink
    (
        .core_clk    (core_clk),
        .arst_n      (arst_n),
        .blink_phase (blink_phase),
        .tick        ()
    );

    always_comb
    begin
        next_green = (sev == fp_led_pkg::LVL_OK) || (sev == fp_led_pkg::LVL_DEGRADED && blink_phase);
        next_amber = (sev == fp_led_pkg::LVL_FATAL) || (sev == fp_led_pkg::LVL_NONFATAL && blink_phase);
        next_ident = (id_state == fp_led_pkg::ID_SOLID)
                     || (id_state == fp_led_pkg::ID_BLINK && blink_phase);
    end

    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            status_green <= 1'b0;
            status_amber <= 1'b0;
            ident_light  <= 1'b0;
        end
        else
        begin
            status_green <= next_green;
            status_amber <= next_amber;
            ident_light  <= next_ident;
        end
    end

endmodule

`default_nettype wire

// File: verification/fp_led_monitor.sv
// checker on the ports of the status and identify lamp block
// assumes the blink phase stays in its dark half for a short run
`timescale 1ns/1ps
`default_nettype none
module fp_led_monitor
(
    input wire logic        core_clk,
    input wire logic        arst_n,
    input wire logic        supplies_insufficient,
    input wire logic        cpu_config_mismatch,
    input wire logic        ident_button_n,
    input wire logic [3:0]  reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic        reg_wr,
    input wire logic        reg_rd,
    input wire logic [31:0] reg_rdata,
    input wire logic        status_green,
    input wire logic        status_amber,
    input wire logic        ident_light
);
    // ********************************************************
    // sequences
    // ********************************************************
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!arst_n);
    sequence s_fw_fatal;
        reg_wr && reg_addr == fp_led_pkg::REG_FW_FAULT && reg_wdata[fp_led_pkg::FW_FATAL];
    endsequence
    // an identify command followed by a quiet button
    sequence s_id_cmd;
        reg_wr && reg_addr == fp_led_pkg::REG_IDENT_CMD && reg_wdata[1:0] != 2'h0 ##1 ident_button_n [*8];
    endsequence
    // ********************************************************
    // assertions
    // ********************************************************
    chk_colour_excl: assert property (!(status_green && status_amber))
        else $error("both status colours lit");
    chk_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
        else $error("read data outside its cycle");
    chk_status_upper: assert property (reg_rd && reg_addr == fp_led_pkg::REG_STATUS |=> reg_rdata[31:7] == 25'h0)
        else $error("status read has stray bits");
    chk_fatal_amber: assert property (cpu_config_mismatch [*8] |-> ##[0:4] status_amber)
        else $error("fatal input without amber");
    chk_fatal_no_green: assert property (supplies_insufficient [*8] ##4 supplies_insufficient |-> !status_green)
        else $error("green lit under fatal input");
    chk_reset_dark: assert property ($rose(arst_n) |-> !status_green && !status_amber && !ident_light)
        else $error("lamp lit at reset release");
    chk_start_dark: assert property ($rose(arst_n) |-> (!status_green && !status_amber) [*4])
        else $error("status lit before evaluation");
    chk_id_cmd_dark: assert property (s_id_cmd |-> !ident_light)
        else $error("commanded identify not in dark phase");
    chk_fw_fatal: assert property (s_fw_fatal |-> ##[1:8] status_amber)
        else $error("firmware fatal not shown");
endmodule
bind fp_status_id_led fp_led_monitor mon (.core_clk, .arst_n, .supplies_insufficient, .cpu_config_mismatch,
    .ident_button_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .status_green, .status_amber, .ident_light);
`default_nettype wire

// File: verification/fp_panel_model.sv
// front panel identify button as a person presses it
// assumes the pin has a pull-up, so a released button reads high
`timescale 1ns/1ps
`default_nettype none
module fp_panel_model
(
    input  wire logic core_clk,
    input  wire logic press_req,
    output var  logic ident_button_n
);
    logic [3:0] hold;
    // a press outlasts the sync chain; ten cycles keeps the run short
    initial
    begin
        hold = 4'h0;
        ident_button_n = 1'h1;
    end
    always @(posedge core_clk)
    begin
        if (press_req)
            hold <= 4'hA;
        else if (hold != 4'h0)
            hold <= hold - 4'h1;
        ident_button_n <= !(press_req || hold > 4'h1);
    end
endmodule
`default_nettype wire

// File: verification/tb_top.sv
// self-checking bench for the status and identify lamp block
// assumes the blink divider stays in its dark half during this short run
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    // ********************************************************
    // signals
    // ********************************************************
    logic        core_clk, arst_n, system_ready, press_req, reg_wr, reg_rd, mem_mir;
    logic [2:0]  ctrl_fault, fw, id_st;
    logic [3:0]  reg_addr;
    logic [7:0]  mem_cnt;
    logic [19:0] sens;
    logic [31:0] reg_wdata, seed, d;
    int          mismatches, n_tests;
    wire logic   supply_redundancy_lost, fan_redundancy_lost, supply_redundant, fan_redundant, one_cpu_disabled,
                 fan_failed, noncritical_crossed, battery_failed, supply_predictive_fail, link_correctable_err,
                 critical_crossed, regulator_overtemp, fans_insufficient, link_uncorrectable_err,
                 cpu_catastrophic_error, cpu_thermal_trip, cpu1_missing, power_fail, supplies_insufficient,
                 cpu_config_mismatch, power_good, ident_button_n, status_green, status_amber, ident_light;
    wire logic [31:0] reg_rdata;
    // one vector drives every sensor so a loop can walk them
    assign {supply_redundancy_lost, fan_redundancy_lost, supply_redundant, fan_redundant, one_cpu_disabled,
            fan_failed, noncritical_crossed, battery_failed, supply_predictive_fail, link_correctable_err,
            critical_crossed, regulator_overtemp, fans_insufficient, link_uncorrectable_err,
            cpu_catastrophic_error, cpu_thermal_trip, cpu1_missing, power_fail, supplies_insufficient,
            cpu_config_mismatch} = sens;
    assign power_good = !power_fail;
    fp_status_id_led uut
    (
        .core_clk, .arst_n, .supply_redundancy_lost, .fan_redundancy_lost, .supply_redundant, .fan_redundant,
        .one_cpu_disabled, .fan_failed, .noncritical_crossed, .battery_failed, .supply_predictive_fail,
        .link_correctable_err, .critical_crossed, .regulator_overtemp, .fans_insufficient, .link_uncorrectable_err,
        .cpu_catastrophic_error, .cpu_thermal_trip, .cpu1_missing, .power_good, .supplies_insufficient,
        .cpu_config_mismatch, .ctrl_fault, .system_ready, .ident_button_n, .reg_addr, .reg_wdata, .reg_wr,
        .reg_rd, .reg_rdata, .status_green, .status_amber, .ident_light
    );
    fp_panel_model panel (.core_clk, .press_req, .ident_button_n);
    initial
    begin
        core_clk = 1'h0;
        forever #2 core_clk = ~core_clk;
    end
    // ********************************************************
    // tasks and expectation functions
    // ********************************************************
    task automatic tick(input int n);
        repeat (n) @(posedge core_clk);
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] v);
        @(posedge core_clk);
        reg_wr    <= 1'h1;
        reg_addr  <= a;
        reg_wdata <= v;
        @(posedge core_clk);
        reg_wr <= 1'h0;
    endtask
    // data stand only in the cycle after the strobe, so sample just past that edge
    task automatic rd(input logic [3:0] a);
        @(posedge core_clk);
        reg_rd   <= 1'h1;
        reg_addr <= a;
        @(posedge core_clk);
        reg_rd <= 1'h0;
        #1 d = reg_rdata;
    endtask
    task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp)
            begin
            mismatches++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic chk_lamp(input logic [2:0] exp);
        chk_reg({29'h0, status_green, status_amber, ident_light}, {29'h0, exp});
    endtask
    function automatic logic [31:0] xorshift(input logic [31:0] x);
        x = x ^ (x << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction
    function automatic logic [2:0] exp_sev();
        if ((|sens[5:0]) || ctrl_fault[2] || fw[2])
            return 3'h4;
        if ((|sens[9:6]) || ctrl_fault[1] || fw[1] || (!mem_mir && mem_cnt > 8'h0A))
            return 3'h3;
        if ((sens[19] && sens[17]) || (sens[18] && sens[16]) || (|sens[15:10]) || ctrl_fault[0] || fw[0])
            return 3'h2;
        return {2'h0, system_ready};
    endfunction
    task automatic settle_check();
        logic [2:0] s;
        tick(16);
        s = exp_sev();
        rd(fp_led_pkg::REG_STATUS);
        chk_reg(d, {25'h0, id_st, 1'h0, s});
        chk_lamp({s == 3'h1, s == 3'h4, id_st == fp_led_pkg::ID_SOLID});
        @(posedge core_clk); // back on an edge so the next stimulus is driven there
    endtask
    task automatic mem_wr(input logic [31:0] v);
        logic [8:0] sum;
        wr(fp_led_pkg::REG_MEM_CE, v);
        sum = {1'h0, mem_cnt} + {1'h0, v[7:0]};
        mem_cnt = v[9] ? 8'h00 : (sum[8] ? 8'hFF : sum[7:0]);
        mem_mir = v[8];
        settle_check();
    endtask
    // k: 0 press, 1 standard on, 2 vendor on, 3 off
    task automatic id_act(input int k);
        if (k == 0)
            begin
            @(posedge core_clk);
            press_req <= 1'h1;
            @(posedge core_clk);
            press_req <= 1'h0;
            id_st = (id_st == fp_led_pkg::ID_SOLID) ? fp_led_pkg::ID_OFF : fp_led_pkg::ID_SOLID;
        end
        else
            begin
            wr(fp_led_pkg::REG_IDENT_CMD, 32'h1 << (k - 1));
            id_st = (k < 3) ? fp_led_pkg::ID_BLINK : fp_led_pkg::ID_OFF;
        end
        settle_check();
    endtask
    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    // ********************************************************
    // main sequence and watchdog
    // ********************************************************
    initial
    begin
        tick(20000);
        mismatches++;
        end_of_test();
    end
    initial
    begin
        {arst_n, press_req, reg_wr, reg_rd, mem_mir, ctrl_fault, fw, reg_addr, mem_cnt, sens} = '0;
        {system_ready, reg_wdata, seed, id_st} = {1'h1, 32'h0, 32'hAC87, fp_led_pkg::ID_OFF};
        tick(6);
        arst_n <= 1'h1;
        tick(1);
        #1 chk_lamp(3'h0);
        settle_check();
        // every sensor alone, redundancy flags alone must not count
        for (int i = 0; i < 20; i++)
            begin
            sens <= 20'h1 << i;
            settle_check();
        end
        sens <= '0;
        for (int i = 0; i < 6; i++)
            begin
            ctrl_fault <= (i < 3) ? 3'h1 << i : 3'h0;
            fw = (i < 3) ? 3'h0 : 3'h1 << (i - 3);
            wr(fp_led_pkg::REG_FW_FAULT, {29'h0, fw});
            settle_check();
        end
        // the fatal report left by the loop would mask every memory alarm below
        fw = 3'h0;
        wr(fp_led_pkg::REG_FW_FAULT, 32'h0);
        // error count exactly at and just past the limit, then mirror and saturation
        mem_wr(32'h0000_000A);
        mem_wr(32'h0000_0001);
        mem_wr(32'h0000_0100);
        rd(fp_led_pkg::REG_MEM_CE);
        chk_reg(d, 32'h0000_010B);
        mem_wr(32'h0000_00FF);
        rd(fp_led_pkg::REG_MEM_CE);
        chk_reg(d, 32'h0000_00FF);
        mem_wr(32'h0000_0200);
        // write-only, read-only and unmapped places
        wr(fp_led_pkg::REG_STATUS, 32'hFFFF_FFFF);
        rd(fp_led_pkg::REG_IDENT_CMD);
        chk_reg(d, 32'h0);
        rd(4'hF);
        chk_reg(d, 32'h0);
        foreach (d[i])
            if (i < 12)
                id_act((i * 7 + i / 4) % 4);
        id_act(2);
        id_act(0);
        id_act(0);
        for (int i = 0; i < 40; i++)
            begin
            seed = xorshift(seed);
            d = seed & xorshift(seed) & xorshift(xorshift(seed));
            sens <= d[19:0];
            ctrl_fault <= d[22:20];
            system_ready <= seed[31];
            fw = d[30:28];
            wr(fp_led_pkg::REG_FW_FAULT, {29'h0, fw});
            settle_check();
        end
        end_of_test();
    end
endmodule
`default_nettype wire
